// ### hw/nand_status_and_otp_control.sv
`timescale 1ns/1ps
module nand_status_and_otp_control
  import nand_status_pkg::*;
#(
  parameter int OTP_PAGE_COUNT = nand_status_pkg::OTP_PAGES
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic                        spi_clk,
  input  wire logic                        spi_cs_n,
  input  wire logic                        spi_mosi,
  output logic                             spi_miso,
  output logic                             spi_miso_oe,
  input  wire logic                        nv_lock_in,
  input  wire logic                        op_done,
  input  wire logic                        op_fail,
  input  wire logic [2:0]                  op_ecc,
  output logic                             op_start,
  output nand_status_pkg::op_kind_t        op_kind,
  output logic [15:0]                      op_row,
  output logic                             op_onetime,
  output logic                             lock_burn,
  output logic                             ecc_enable
);
  import nand_status_pkg::*;

  initial begin
    if (OTP_PAGE_COUNT < 1 || OTP_PAGE_COUNT > 65535)
      $error("OTP_PAGE_COUNT out of range");
  end

  // Link side: shift in on rising edges, answer on falling edges.
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [6:0] shreg_q, shreg_d;
  logic [1:0] lidx_q, lidx_d;
  logic       last_bit;
  logic [7:0] link_byte_q, link_byte_d;
  logic [7:0] lcmd_q, lcmd_d;
  logic       byte_tgl_q, byte_tgl_d;
  logic       link_clr_q;
  logic [7:0] resp_q, resp_d;

  always_comb begin
    last_bit    = (bit_cnt_q == 3'h7);
    bit_cnt_d   = bit_cnt_q + 3'h1;
    shreg_d     = {shreg_q[5:0], spi_mosi};
    lidx_d      = lidx_q;
    link_byte_d = link_byte_q;
    lcmd_d      = lcmd_q;
    byte_tgl_d  = byte_tgl_q;
    if (last_bit) begin
      if (lidx_q != LIDX_DATA) lidx_d = lidx_q + 2'h1;
      link_byte_d = {shreg_q, spi_mosi};
      byte_tgl_d  = ~byte_tgl_q;
      if (lidx_q == 2'h0) lcmd_d = {shreg_q, spi_mosi};
    end
  end

  // Chip select ends the frame; the clock may stop right after.
  always_ff @(posedge spi_clk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt_q <= 3'h0;
      shreg_q   <= 7'h00;
      lidx_q    <= 2'h0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      shreg_q   <= shreg_d;
      lidx_q    <= lidx_d;
    end
  end

  always_ff @(posedge spi_clk or posedge link_clr_q) begin
    if (link_clr_q) begin
      link_byte_q <= 8'h00;
      lcmd_q      <= 8'h00;
      byte_tgl_q  <= 1'b0;
    end else begin
      link_byte_q <= link_byte_d;
      lcmd_q      <= lcmd_d;
      byte_tgl_q  <= byte_tgl_d;
    end
  end

  // The answer byte is quasi-static: the host leaves a gap after the
  // address byte so the system side can load it before it is shifted.
  always_ff @(negedge spi_clk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else if (lidx_q == LIDX_DATA && lcmd_q == OP_GET_FEAT) begin
      spi_miso    <= resp_q[3'h7 - bit_cnt_q];
      spi_miso_oe <= 1'b1;
    end
  end

  // System side.
  logic [2:0] sync_s;
  logic       tgl_s, cs_s, nv_lock_s;

  bit_sync #(.WIDTH(3)) u_sync (
    .clk      (sys_clk),
    .rstn     (rstn),
    .async_in ({nv_lock_in, spi_cs_n, byte_tgl_q}),
    .sync_out (sync_s)
  );
  assign {nv_lock_s, cs_s, tgl_s} = sync_s;

  function automatic logic [7:0] feat_read(input logic [7:0] addr,
                                           input logic [7:0] status,
                                           input logic [7:0] otp);
    if (addr == FEAT_STATUS) feat_read = status;
    else if (addr == FEAT_OTP_CTRL) feat_read = otp;
    else feat_read = 8'h00;
  endfunction : feat_read

  op_state_t  st_q, st_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] cmd_q, cmd_d, b1_q, b1_d, b2_q, b2_d, b3_q, b3_d;
  logic       wel_q, wel_d, pfail_q, pfail_d, efail_q, efail_d;
  logic [2:0] ecc_q, ecc_d;
  logic       otp_en_q, otp_en_d, lock_req_q, lock_req_d;
  logic       locked_q, locked_d, ecc_en_q, ecc_en_d;
  logic       op_start_d, op_onetime_d, lock_burn_d;
  op_kind_t   op_kind_d;
  logic [15:0] op_row_d;
  logic       tgl_prev_q, cs_prev_q, link_clr_d;
  logic       byte_ev, frame_end;
  logic [7:0] status_w, otp_w;

  always_comb begin
    logic     go;
    logic     do_start;
    logic     row_ok;
    op_kind_t kind;
    go        = 1'b0;
    do_start  = 1'b0;
    row_ok    = (idx_q == IDX_ROW_FULL);
    kind      = OPK_READ;
    byte_ev   = tgl_s ^ tgl_prev_q;
    frame_end = cs_s & ~cs_prev_q;
    link_clr_d = ~rstn;
    status_w = 8'h00;                                    // RQ24
    status_w[ST_BUSY]  = (st_q == S_BUSY);
    status_w[ST_WEL]   = wel_q;
    status_w[ST_EFAIL] = efail_q;
    status_w[ST_PFAIL] = pfail_q;
    status_w[ST_ECC_LSB +: 3] = ecc_q;                   // RQ10
    otp_w = 8'h00;
    otp_w[OC_ONETIME_LOCK_BIT] = locked_q | lock_req_q;           // RQ15
    otp_w[OC_OTP_EN]  = otp_en_q;
    otp_w[OC_ECC_EN]  = ecc_en_q;
    st_d = st_q;  idx_d = idx_q;  cmd_d = cmd_q;
    b1_d = b1_q;  b2_d = b2_q;  b3_d = b3_q;  resp_d = resp_q;
    wel_d = wel_q;  pfail_d = pfail_q;  efail_d = efail_q;
    ecc_d = ecc_q;  otp_en_d = otp_en_q;  lock_req_d = lock_req_q;
    locked_d = locked_q | nv_lock_s;                     // RQ20
    ecc_en_d = ecc_en_q;
    op_start_d = 1'b0;  op_kind_d = op_kind;  op_row_d = op_row;
    op_onetime_d = op_onetime;  lock_burn_d = 1'b0;

    if (byte_ev) begin
      if (idx_q == 3'h0) cmd_d = link_byte_q;
      else if (idx_q == 3'h1) b1_d = link_byte_q;
      else if (idx_q == 3'h2) b2_d = link_byte_q;
      else if (idx_q == 3'h3) b3_d = link_byte_q;
      if (idx_q != IDX_ROW_FULL) idx_d = idx_q + 3'h1;
      if (idx_q == IDX_RESP && cmd_q == OP_GET_FEAT)
        resp_d = feat_read(link_byte_q, status_w, otp_w); // RQ1
    end

    if (frame_end) begin
      idx_d = 3'h0;
      go = (st_q == S_IDLE) || (cmd_q == OP_RESET);      // RQ8
      if (go && idx_q != 3'h0) begin
        case (cmd_q)
          OP_WREN: wel_d = 1'b1;                         // RQ6
          OP_WRDI: wel_d = 1'b0;                         // RQ6
          OP_SET_FEAT: begin
            // Writes to the status address fall through untouched.
            if (idx_q >= IDX_FEAT_DATA && b1_q == FEAT_OTP_CTRL) begin
              otp_en_d   = b2_q[OC_OTP_EN];              // RQ19
              lock_req_d = b2_q[OC_ONETIME_LOCK_BIT];
              ecc_en_d   = b2_q[OC_ECC_EN];
            end
          end
          OP_RESET: begin
            pfail_d  = 1'b0;                             // RQ3
            efail_d  = 1'b0;                             // RQ5
            ecc_d    = ECC_NONE;                         // RQ12
            do_start = 1'b1;
            kind     = OPK_RESET;
          end
          OP_PAGE_READ: if (row_ok) begin
            ecc_d    = ECC_NONE;                         // RQ12
            do_start = 1'b1;                             // RQ18
            kind     = OPK_READ;
          end
          OP_PROG_EXEC: if (row_ok) begin
            pfail_d = 1'b0;                              // RQ3
            if (wel_q) begin                             // RQ6
              wel_d = 1'b0;
              if (otp_en_q && locked_q) begin
                pfail_d = 1'b1;                          // RQ21
              end else if (otp_en_q && lock_req_q) begin
                do_start    = 1'b1;                      // RQ19 RQ22
                kind        = OPK_OTP_LOCK;
                lock_burn_d = 1'b1;
              end else if (otp_en_q &&
                           {b2_q, b3_q} >= 16'(OTP_PAGE_COUNT)) begin
                pfail_d = 1'b1;                          // RQ14 RQ2
              end else begin
                do_start = 1'b1;                         // RQ18
                kind     = OPK_PROG;
              end
            end
          end
          OP_ERASE: if (row_ok) begin
            efail_d = 1'b0;                              // RQ5
            if (wel_q) begin                             // RQ6
              wel_d = 1'b0;
              if (otp_en_q) efail_d = 1'b1;              // RQ21 RQ4
              else begin
                do_start = 1'b1;
                kind     = OPK_ERASE;
              end
            end
          end
          OP_GLOB_LOCK, OP_GLOB_ULCK: begin
            do_start = 1'b1;                             // RQ7
            kind     = OPK_LOCK;
          end
          OP_BLK_LOCK, OP_BLK_ULCK: if (row_ok) begin
            do_start = 1'b1;                             // RQ7
            kind     = OPK_LOCK;
          end
          default: ;
        endcase
      end
    end

    // Completion is applied after the frame so a late failure report
    // wins over a clear issued in the same cycle.
    if (st_q == S_BUSY && op_done) begin
      st_d = S_IDLE;                                     // RQ9
      case (op_kind)
        OPK_PROG:  if (op_fail) pfail_d = 1'b1;          // RQ2
        OPK_ERASE: if (op_fail) efail_d = 1'b1;          // RQ4
        OPK_READ:  if (ecc_en_q) ecc_d = op_ecc;         // RQ12
        OPK_OTP_LOCK: begin
          if (op_fail) pfail_d = 1'b1;
          else locked_d = 1'b1;                          // RQ20
        end
        default: ;
      endcase
    end

    if (do_start) begin
      st_d         = S_BUSY;                             // RQ7
      op_start_d   = 1'b1;
      op_kind_d    = kind;
      op_row_d     = {b2_q, b3_q};
      op_onetime_d = otp_en_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_q <= S_IDLE;  idx_q <= 3'h0;  cmd_q <= 8'h00;
      b1_q <= 8'h00;  b2_q <= 8'h00;  b3_q <= 8'h00;  resp_q <= 8'h00;
      wel_q <= 1'b0;  pfail_q <= 1'b0;  efail_q <= 1'b0;
      ecc_q <= ECC_NONE;                                 // RQ12
      otp_en_q <= 1'b0;  lock_req_q <= 1'b0;
      locked_q <= 1'b0;                                  // RQ15
      ecc_en_q <= 1'b1;                                  // RQ23
      op_start <= 1'b0;  op_kind <= OPK_READ;  op_row <= 16'h0000;
      op_onetime <= 1'b0;  lock_burn <= 1'b0;  ecc_enable <= 1'b1;
      tgl_prev_q <= 1'b0;  cs_prev_q <= 1'b1;  link_clr_q <= 1'b1;
    end else begin
      st_q <= st_d;  idx_q <= idx_d;  cmd_q <= cmd_d;
      b1_q <= b1_d;  b2_q <= b2_d;  b3_q <= b3_d;  resp_q <= resp_d;
      wel_q <= wel_d;  pfail_q <= pfail_d;  efail_q <= efail_d;
      ecc_q <= ecc_d;  otp_en_q <= otp_en_d;  lock_req_q <= lock_req_d;
      locked_q <= locked_d;  ecc_en_q <= ecc_en_d;
      op_start <= op_start_d;  op_kind <= op_kind_d;  op_row <= op_row_d;
      op_onetime <= op_onetime_d;  lock_burn <= lock_burn_d;
      ecc_enable <= ecc_en_d;
      tgl_prev_q <= tgl_s;  cs_prev_q <= cs_s;  link_clr_q <= link_clr_d;
    end
  end

  property p_busy_on_start;
    @(posedge sys_clk) disable iff (!rstn)
    op_start |-> (st_q == S_BUSY) [*2] or (st_q == S_BUSY ##1 op_done);
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) // RQ7
    else $error("busy not held after an operation start");

  property p_ready_after_done;
    @(posedge sys_clk) disable iff (!rstn)
    (st_q == S_BUSY && op_done && !frame_end) |=> st_q == S_IDLE;
  endproperty
  a_ready_after_done: assert property (p_ready_after_done) // RQ9
    else $error("busy not cleared after completion");

  property p_wel_set;
    @(posedge sys_clk) disable iff (!rstn)
    (frame_end && st_q == S_IDLE && cmd_q == OP_WREN && idx_q != 3'h0)
      |=> wel_q ##1 resp_q == $past(resp_q) || byte_ev;
  endproperty
  a_wel_set: assert property (p_wel_set) // RQ6
    else $error("write-enable latch not set");

  property p_pfail_clear;
    @(posedge sys_clk) disable iff (!rstn)
    (frame_end && st_q == S_IDLE && cmd_q == OP_PROG_EXEC &&
     idx_q == IDX_ROW_FULL && !otp_en_q) |=> !pfail_q;
  endproperty
  a_pfail_clear: assert property (p_pfail_clear) // RQ3
    else $error("program-fail not cleared by execute");

  property p_pfail_set;
    @(posedge sys_clk) disable iff (!rstn)
    (st_q == S_BUSY && op_done && op_fail && op_kind == OPK_PROG)
      |=> pfail_q;
  endproperty
  a_pfail_set: assert property (p_pfail_set) // RQ2
    else $error("program failure not flagged");

  property p_otp_no_erase;
    @(posedge sys_clk) disable iff (!rstn)
    (frame_end && st_q == S_IDLE && cmd_q == OP_ERASE &&
     idx_q == IDX_ROW_FULL && wel_q && otp_en_q)
      |=> efail_q && !op_start;
  endproperty
  a_otp_no_erase: assert property (p_otp_no_erase) // RQ21
    else $error("one-time area erase not refused");

  property p_ecc_read_start;
    @(posedge sys_clk) disable iff (!rstn)
    (frame_end && st_q == S_IDLE && cmd_q == OP_PAGE_READ &&
     idx_q == IDX_ROW_FULL) |=> ecc_q == ECC_NONE && st_q == S_BUSY;
  endproperty
  a_ecc_read_start: assert property (p_ecc_read_start) // RQ12
    else $error("correction code not zeroed at read start");

  property p_lock_sticky;
    @(posedge sys_clk) disable iff (!rstn)
    locked_q |=> locked_q [*3];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) // RQ20
    else $error("one-time lock bit fell");

  property p_status_read;
    @(posedge sys_clk) disable iff (!rstn)
    (byte_ev && idx_q == IDX_RESP && cmd_q == OP_GET_FEAT &&
     link_byte_q == FEAT_STATUS)
      |=> resp_q[7] == 1'b0 && resp_q[ST_WEL] == $past(wel_q);
  endproperty
  a_status_read: assert property (p_status_read) // RQ1
    else $error("status answer wrong");

  property p_ecc_on_after_reset;
    @(posedge sys_clk) disable iff (!rstn)
    !$past(rstn) |-> ecc_en_q && ecc_enable;
  endproperty
  a_ecc_on_after_reset: assert property (p_ecc_on_after_reset) // RQ23
    else $error("correction not enabled after reset");
endmodule : nand_status_and_otp_control

// ### hw/nand_status_pkg.sv
// Operation
// RQ1 - Status readable at C0h through get-features.
// RQ2 - Program failure or refused program sets flag.
// RQ3 - Program-fail flag clears on execute or reset.
// RQ4 - Erase failure or refused erase sets flag.
// RQ5 - Erase-fail flag clears on erase or reset.
// RQ6 - Write-enable sets latch, write-disable clears it.
// RQ7 - Busy held during every long operation.
// RQ8 - Host sends only 0Fh or FFh while busy.
// RQ9 - Busy clears when ready for commands.
// RQ10 - Three-bit correction code meanings as listed.
// RQ11 - Host refreshes block when code reads 110b.
// RQ12 - Code zeroed at reset and read start.
// RQ13 - Host ignores code while correction disabled.
// RQ14 - Eight one-time pages of 2176 bytes.
// RQ15 - Lock bit reads zero when never locked; the code reads it as one once set-features writes it, before any lock.
// RQ16 - Host enables one-time access at B0h.
// RQ17 - Host programs one-time pages in ascending order.
// RQ18 - One-time pages programmed and read when enabled.
// RQ19 - Enable plus lock plus execute locks area.
// RQ20 - Locked area stays locked, reads only.
// RQ21 - One-time area never erased, nor reprogrammed locked.
// RQ22 - Host locks via set-features, write-enable, execute.
// RQ23 - Internal correction enabled after power-up.
// RQ24 - Unused status bits zero, status writes ignored.
package nand_status_pkg;

  localparam logic [7:0] FEAT_OTP_CTRL = 8'hB0;
  localparam logic [7:0] FEAT_STATUS   = 8'hC0;

  localparam logic [7:0] OP_WREN       = 8'h06;
  localparam logic [7:0] OP_WRDI       = 8'h04;
  localparam logic [7:0] OP_GET_FEAT   = 8'h0F;
  localparam logic [7:0] OP_SET_FEAT   = 8'h1F;
  localparam logic [7:0] OP_PROG_EXEC  = 8'h10;
  localparam logic [7:0] OP_PAGE_READ  = 8'h13;
  localparam logic [7:0] OP_ERASE      = 8'hD8;
  localparam logic [7:0] OP_RESET      = 8'hFF;
  localparam logic [7:0] OP_GLOB_LOCK  = 8'h7E;
  localparam logic [7:0] OP_GLOB_ULCK  = 8'h98;
  localparam logic [7:0] OP_BLK_LOCK   = 8'h36;
  localparam logic [7:0] OP_BLK_ULCK   = 8'h39;

  // Status bit positions.
  localparam int ST_BUSY    = 0;
  localparam int ST_WEL     = 1;
  localparam int ST_EFAIL   = 2;
  localparam int ST_PFAIL   = 3;
  localparam int ST_ECC_LSB = 4;
  // One-time control bit positions.
  localparam int OC_ECC_EN  = 4;
  localparam int OC_OTP_EN  = 6;
  localparam int OC_ONETIME_LOCK_BIT = 7;

  localparam logic [2:0] ECC_NONE   = 3'h0;
  localparam logic [2:0] ECC_FIXED3 = 3'h1;
  localparam logic [2:0] ECC_REFRESH = 3'h6;
  localparam logic [2:0] ECC_UNCORR = 3'h7;

  localparam int OTP_PAGES      = 8;
  localparam int OTP_PAGE_BYTES = 2176;

  // Byte counts of a frame: opcode, then address or feature bytes.
  localparam logic [2:0] IDX_FEAT_DATA = 3'h3;
  localparam logic [2:0] IDX_ROW_FULL  = 3'h4;
  localparam logic [2:0] IDX_RESP      = 3'h1;
  localparam logic [1:0] LIDX_DATA     = 2'h2;

  typedef enum logic [2:0] {
    OPK_READ     = 3'h0,
    OPK_PROG     = 3'h1,
    OPK_ERASE    = 3'h2,
    OPK_RESET    = 3'h3,
    OPK_LOCK     = 3'h4,
    OPK_OTP_LOCK = 3'h5
  } op_kind_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_BUSY = 2'b10
  } op_state_t;

endpackage : nand_status_pkg

// ### hw/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  initial begin
    if (WIDTH < 1) $error("bit_sync: WIDTH must be at least 1");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q;
    logic hold_q;
    always_ff @(posedge clk) begin
      if (!rstn) begin
        meta_q <= 1'b0;
        hold_q <= 1'b0;
      end else begin
        meta_q <= async_in[i];
        hold_q <= meta_q;
      end
    end
    assign sync_out[i] = hold_q;
  end
endmodule : bit_sync

// ### verification/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model
  import nand_status_pkg::*;
(
  output logic       spi_clk,
  output logic       spi_cs_n,
  output logic       spi_mosi,
  input  wire logic  spi_miso,
  input  wire logic  spi_miso_oe,
  output logic [7:0] rd_data,
  output int         rd_cnt
);
  initial begin
    spi_clk  = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    rd_data  = 8'h00;
    rd_cnt   = 0;
  end

  // Mode 0: data changes while the clock is low and is taken on its rise.
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      spi_clk  = 1'b0;
      spi_mosi = b[i];
      #6;
      spi_clk = 1'b1;
      #6;
    end
  endtask : put_byte

  // The clock stops low between frames and the data line is scrambled.
  task automatic end_frame();
    #6;
    spi_clk  = 1'b0;
    spi_mosi = ~spi_mosi;
    #20;
    spi_cs_n = 1'b1;
    #300;
  endtask : end_frame

  task automatic frame(input logic [31:0] w, input int n);
    spi_cs_n = 1'b0;
    #20;
    for (int k = 0; k < n; k++) put_byte(w[31-8*k -: 8]);
    end_frame();
  endtask : frame

  task automatic get_feat(input logic [7:0] a);
    logic [7:0] v;
    spi_cs_n = 1'b0;
    #20;
    put_byte(OP_GET_FEAT);
    put_byte(a);
    #300;
    for (int i = 7; i >= 0; i--) begin
      spi_clk  = 1'b0;
      spi_mosi = ~spi_mosi;
      #6;
      spi_clk = 1'b1;
      v[i]    = spi_miso_oe ? spi_miso : 1'bx;
      #6;
    end
    end_frame();
    rd_data = v;
    rd_cnt++;
  endtask : get_feat
endmodule : spi_host_model

// ### verification/nand_status_and_otp_control_tb.sv
`timescale 1ns/1ps
module nand_status_and_otp_control_tb;
  import nand_status_pkg::*;
  localparam logic [4:0] K_READ  = {2'b00, OPK_READ};
  localparam logic [4:0] K_PROG  = {2'b00, OPK_PROG};
  localparam logic [4:0] K_ERASE = {2'b00, OPK_ERASE};
  localparam logic [4:0] K_OPROG = {2'b01, OPK_PROG};
  localparam logic [4:0] K_OREAD = {2'b01, OPK_READ};
  localparam logic [4:0] K_LOCK  = {2'b11, OPK_OTP_LOCK};
  localparam logic [4:0] K_BLK   = {2'b00, OPK_LOCK};
  localparam logic [4:0] NO_OP   = 5'h1F;

  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic        nv_lock_in = 1'b0;
  logic        op_done = 1'b0;
  logic        op_fail = 1'b0;
  logic [2:0]  op_ecc = 3'h0;
  logic        op_start, op_onetime, lock_burn, ecc_enable;
  op_kind_t    op_kind;
  logic [15:0] op_row;
  logic [7:0]  rd_data;
  int          rd_cnt, error_cnt, total_checks, cnt, cyc;
  logic        slow = 1'b0;
  logic        e_fail = 1'b0;
  logic        burn_q = 1'b0;
  logic        d;
  logic [2:0]  e_ecc = 3'h0;
  logic [20:0] x;
  logic [15:0] r;
  logic [7:0]  q[$];
  logic [20:0] kq[$];

  nand_status_and_otp_control uut (
    .sys_clk(sys_clk), .rstn(rstn), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .nv_lock_in(nv_lock_in),
    .op_done(op_done), .op_fail(op_fail), .op_ecc(op_ecc),
    .op_start(op_start), .op_kind(op_kind), .op_row(op_row),
    .op_onetime(op_onetime), .lock_burn(lock_burn),
    .ecc_enable(ecc_enable)
  );

  spi_host_model host (
    .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .rd_data(rd_data), .rd_cnt(rd_cnt)
  );

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [20:0] s,
                       input logic [20:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end

  always @(rd_cnt) begin
    if (rd_cnt > 0)
      check("feature", {13'h0, rd_data}, {13'h0, q.pop_front()});
  end

  // Array engine stand-in; flags are scrambled outside the done pulse.
  always @(negedge sys_clk) begin
    d = (cnt == 1);
    if (cnt > 0) cnt--;
    op_done <= d;
    op_fail <= d ? e_fail : 1'($urandom);
    op_ecc  <= d ? e_ecc : 3'($urandom);
    if (d && burn_q && !e_fail) nv_lock_in <= 1'b1;
    if (!rstn) cnt = 0;
    else if (op_start === 1'b1) begin
      x = (kq.size() > 0) ? kq.pop_front() : 21'h1FFFFF;
      // A reset carries no row, so its row is not compared.
      if (x[18:16] == OPK_RESET) x[15:0] = op_row;
      check("op", {lock_burn, op_onetime, op_kind, op_row},
            x);
      burn_q = lock_burn;
      cnt = slow ? 150 : 2 + int'($urandom % 19);
    end
  end

  function automatic logic [15:0] rnd();
    return 16'($urandom);
  endfunction : rnd

  task automatic do_reset();
    @(negedge sys_clk);
    rstn = 1'b0;
    repeat (16) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : do_reset

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    host.get_feat(a);
  endtask : rd

  task automatic cmd1(input logic [7:0] c);
    host.frame({c, 24'h0}, 1);
  endtask : cmd1

  task automatic sf(input logic [7:0] a, input logic [7:0] v);
    host.frame({OP_SET_FEAT, a, v, 8'h00}, 3);
  endtask : sf

  task automatic op(input logic [7:0] c, input logic [15:0] r,
                    input logic [4:0] k, input logic f, input logic [2:0] e);
    if (k !== NO_OP) kq.push_back({k, r});
    e_fail = f;
    e_ecc  = e;
    host.frame({c, 8'h00, r}, 4);
  endtask : op

  task automatic idle();
    for (int i = 0; i < 300 && cnt > 0; i++) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
  endtask : idle

  initial begin
    void'($urandom(32'hBA9FBAC3));
    do_reset();
    rd(FEAT_STATUS, 8'h00);
    rd(FEAT_OTP_CTRL, 8'h10);
    rd(8'hA0, 8'h00);
    check("ecc_en", {20'h0, ecc_enable}, 21'h1);
    sf(FEAT_STATUS, 8'hFF);
    rd(FEAT_STATUS, 8'h00);
    cmd1(OP_WREN);
    rd(FEAT_STATUS, 8'h02);
    cmd1(OP_WRDI);
    op(OP_PROG_EXEC, rnd(), NO_OP, 1'b0, 3'h0);
    rd(FEAT_STATUS, 8'h00);
    for (int e = 0; e < 8; e++) begin
      r = rnd();
      op(OP_PAGE_READ, r, K_READ, 1'b0, 3'(e));
      idle();
      rd(FEAT_STATUS, {1'b0, 3'(e), 4'h0});
      // A marginal read is followed by a rewrite of the same row.
      if (3'(e) == ECC_REFRESH) begin
        cmd1(OP_WREN);
        op(OP_PROG_EXEC, r, K_PROG, 1'b0, 3'h0);
        idle();
      end
    end
    r = rnd();
    op(OP_BLK_LOCK, r, K_BLK, 1'b0, 3'h0);
    idle();
    // An opcode-only lock keeps the row of the frame before it.
    kq.push_back({K_BLK, r});
    cmd1(OP_GLOB_ULCK);
    idle();
    // A long program lets the status be read mid-operation.
    cmd1(OP_WREN);
    slow = 1'b1;
    op(OP_PROG_EXEC, rnd(), K_PROG, 1'b1, 3'h0);
    rd(FEAT_STATUS, 8'h71);
    cmd1(OP_WREN);
    idle();
    slow = 1'b0;
    rd(FEAT_STATUS, 8'h78);
    cmd1(OP_WREN);
    op(OP_ERASE, rnd(), K_ERASE, 1'b1, 3'h0);
    idle();
    rd(FEAT_STATUS, 8'h7C);
    cmd1(OP_WREN);
    op(OP_PROG_EXEC, rnd(), K_PROG, 1'b0, 3'h0);
    idle();
    rd(FEAT_STATUS, 8'h74);
    cmd1(OP_WREN);
    kq.push_back({2'b00, OPK_RESET, 16'h0000});
    cmd1(OP_RESET);
    idle();
    rd(FEAT_STATUS, 8'h02);
    cmd1(OP_WRDI);
    op(OP_PAGE_READ, rnd(), K_READ, 1'b0, 3'h5);
    idle();
    sf(FEAT_OTP_CTRL, 8'h00);
    check("ecc_en", {20'h0, ecc_enable}, 21'h0);
    op(OP_PAGE_READ, rnd(), K_READ, 1'b0, 3'h3);
    idle();
    rd(FEAT_STATUS, 8'h00);
    sf(FEAT_OTP_CTRL, 8'h50);
    rd(FEAT_OTP_CTRL, 8'h50);
    cmd1(OP_WREN);
    op(OP_PROG_EXEC, 16'h0003, K_OPROG, 1'b0, 3'h0);
    idle();
    op(OP_PAGE_READ, 16'h0003, K_OREAD, 1'b0, 3'h1);
    idle();
    rd(FEAT_STATUS, 8'h10);
    cmd1(OP_WREN);
    op(OP_PROG_EXEC, 16'(OTP_PAGES), NO_OP, 1'b0, 3'h0);
    cmd1(OP_WREN);
    op(OP_ERASE, 16'h0003, NO_OP, 1'b0, 3'h0);
    cmd1(OP_WRDI);
    rd(FEAT_STATUS, 8'h1C);
    sf(FEAT_OTP_CTRL, 8'hD0);
    cmd1(OP_WREN);
    op(OP_PROG_EXEC, 16'h0000, K_LOCK, 1'b0, 3'h0);
    idle();
    rd(FEAT_OTP_CTRL, 8'hD0);
    sf(FEAT_OTP_CTRL, 8'h50);
    rd(FEAT_OTP_CTRL, 8'hD0);
    cmd1(OP_WREN);
    op(OP_PROG_EXEC, 16'h0004, NO_OP, 1'b0, 3'h0);
    cmd1(OP_WRDI);
    rd(FEAT_STATUS, 8'h1C);
    // The lock must come back from the fuse store after a fresh reset.
    do_reset();
    rd(FEAT_OTP_CTRL, 8'h90);
    rd(FEAT_STATUS, 8'h00);
    give_verdict();
  end
endmodule : nand_status_and_otp_control_tb
